// ==== src/mmbx_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmbx_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the sequencer
    input wire logic exec_start,
    input wire logic [15:0] instr_word,
    input wire logic [15:0] source_operand,
    input wire logic [15:0] dest_reg,
    input wire logic [15:0] dest_next,
    input wire logic [15:0] count_reg_zero,
    input wire logic [15:0] io_base_reg,
    // Decode seen by the sequencer
    output logic exec_busy,
    output logic [3:0] dest_index,
    output logic [1:0] src_mode,
    output logic [3:0] src_reg,
    output logic pair_in_memory,
    output logic operand_is_byte,
    output logic [1:0] autoinc_step,
    output logic unknown_op,
    // Results
    output logic exec_done,
    output logic [15:0] result_hi,
    output logic [15:0] result_lo,
    output logic write_hi,
    output logic write_lo,
    output logic write_src,
    output logic [5:0] status_flags,
    output logic [5:0] status_touched,
    // Bit-serial space
    output logic [11:0] io_bit_addr,
    output logic io_bit_out,
    output logic io_bit_strobe,
    input wire logic io_bit_in
);
    typedef enum logic [1:0] {EX_IDLE, EX_SERIAL, EX_DONE} mmbx_state_e;

    // Zero compare: bit 0 logical greater, 1 arith greater, 2 equal
    function automatic logic [2:0] cmp_zero(input logic [15:0] v, input logic byt);
        logic [15:0] w;
        w = byt ? {{8{v[7]}}, v[7:0]} : v;
        cmp_zero = {w == 16'h0000, !w[15] && w != 16'h0000, w != 16'h0000};
    endfunction

    // Bit-at-a-time shift; returns {overflow, carry, result}
    function automatic logic [17:0] shift_f(input logic [1:0] k, input logic [15:0] v, input logic [4:0] n);
        logic [15:0] r;
        logic c;
        logic o;
        r = v;
        c = 1'b0;
        o = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (5'(i) < n) begin
                unique case (k)
                    mmbx_pkg::SH_ARITH_LEFT: begin
                        c = r[15];
                        r = {r[14:0], 1'b0};
                        o = o | r[15];
                    end
                    mmbx_pkg::SH_ARITH_RIGHT: begin
                        c = r[0];
                        r = {r[15], r[15:1]};
                    end
                    mmbx_pkg::SH_LOGIC_RIGHT: begin
                        c = r[0];
                        r = {1'b0, r[15:1]};
                    end
                    mmbx_pkg::SH_ROTATE_RIGHT: begin
                        c = r[0];
                        r = {r[0], r[15:1]};
                    end
                endcase
            end
        end
        shift_f = {o, c, r};
    endfunction

    mmbx_ser_if sif();
    mmbx_state_e state_ff; // Sequencing state
    logic [1:0] sync_ff; // Pin synchroniser
    logic [5:0] opc; // Leading six bits
    logic [1:0] shk; // Shift kind
    logic is_shift; // Shift group
    logic [3:0] bcnt; // Serial count field
    logic [3:0] shcnt; // Shift count field
    logic [4:0] ser_n; // Serial bits to move
    logic [4:0] sh_n; // Shift amount
    logic ser_op; // Serial transfer
    logic take; // Request accepted
    logic [31:0] prod; // Multiply product
    logic [31:0] pair; // Divide dividend
    logic [15:0] quo; // Quotient
    logic [15:0] rem; // Remainder
    logic [17:0] shr; // Shift outcome
    logic [15:0] src_ff; // Operand copy for serial flags
    logic ser_load_ff; // Direction of running transfer
    logic ser_byte_ff; // Byte sized transfer
    logic [15:0] ser_val; // Value compared after a transfer
    logic [15:0] hi_ff; // Result registers
    logic [15:0] lo_ff;
    logic whi_ff;
    logic wlo_ff;
    logic wsrc_ff;
    logic done_ff;
    logic [5:0] st_ff;
    logic [5:0] touch_ff;
    logic pmem_ff;
    logic byte_ff;
    logic [1:0] ainc_ff;

    // Field decode; opcode in the leading bits
    assign opc = instr_word[15:mmbx_pkg::OPC_LSB];
    assign is_shift = (opc == mmbx_pkg::OP_SHIFT_HI);
    assign shk = instr_word[mmbx_pkg::SHK_LSB +: 2];
    assign bcnt = instr_word[mmbx_pkg::BCNT_LSB +: 4];
    assign shcnt = instr_word[mmbx_pkg::SHCNT_LSB +: 4];
    assign ser_op = (opc == mmbx_pkg::OP_SER_LOAD) || (opc == mmbx_pkg::OP_SER_STORE);
    assign ser_n = (bcnt == 4'h0) ? 5'h10 : {1'b0, bcnt};
    // Count from register zero when the field is empty
    assign sh_n = (shcnt != 4'h0) ? {1'b0, shcnt} :
                  (count_reg_zero[3:0] != 4'h0) ? {1'b0, count_reg_zero[3:0]} : 5'h10;
    assign take = exec_start && (state_ff == EX_IDLE);
    assign prod = 32'(dest_reg) * 32'(source_operand);
    assign pair = {dest_reg, dest_next};
    // Dividing is only meaningful once overflow is ruled out
    assign quo = (source_operand > dest_reg) ? 16'(pair / 32'(source_operand)) : 16'h0000;
    assign rem = (source_operand > dest_reg) ? 16'(pair % 32'(source_operand)) : 16'h0000;
    assign shr = shift_f(shk, dest_reg, sh_n);

    // Decode outputs for the sequencer's operand fetch
    assign dest_index = instr_word[mmbx_pkg::DST_LSB +: 4];
    assign src_mode = instr_word[mmbx_pkg::MODE_LSB +: 2];
    assign src_reg = instr_word[mmbx_pkg::REG_LSB +: 4];
    assign unknown_op = !is_shift && !(opc >= mmbx_pkg::OP_ONES_MASK && opc != 6'h0B && opc <= mmbx_pkg::OP_DIV);
    assign exec_busy = (state_ff != EX_IDLE);

    // Launch of the serial engine
    assign sif.go = take && ser_op;
    assign sif.load = (opc == mmbx_pkg::OP_SER_LOAD);
    assign sif.cnt = ser_n;
    assign sif.base = io_base_reg[mmbx_pkg::IOBASE_LSB +: 12];
    assign sif.wdata = source_operand;

    mmbx_serial u_serial (
        .clk(clk),
        .rst_n(rst_n),
        .sif(sif),
        .io_bit_addr(io_bit_addr),
        .io_bit_out(io_bit_out),
        .io_bit_strobe(io_bit_strobe),
        .io_bit_in_sync(sync_ff[1])
    );

    // Pin input crosses into the clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff <= 2'b00;
        end else begin
            sync_ff <= {sync_ff[0], io_bit_in};
        end
    end

    // Sequencing: one cycle for datapath work, longer for serial
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= EX_IDLE;
        end else begin
            unique case (state_ff)
                EX_IDLE: begin
                    if (take) begin
                        state_ff <= ser_op ? EX_SERIAL : EX_DONE;
                    end
                end
                EX_SERIAL: begin
                    if (sif.done) begin
                        state_ff <= EX_DONE;
                    end
                end
                EX_DONE: begin
                    state_ff <= EX_IDLE;
                end
            endcase
        end
    end

    // Address sizing and autoincrement step, held for the whole op
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pmem_ff <= 1'b0;
            byte_ff <= 1'b0;
            ainc_ff <= 2'h0;
        end else if (take) begin
            pmem_ff <= (dest_index == mmbx_pkg::LAST_WREG) &&
                       (opc == mmbx_pkg::OP_MUL || opc == mmbx_pkg::OP_DIV);
            byte_ff <= ser_op && ser_n <= 5'(mmbx_pkg::BYTE_MAX);
            if (ser_op && src_mode == mmbx_pkg::MODE_AUTOINC) begin
                ainc_ff <= (ser_n <= 5'(mmbx_pkg::BYTE_MAX)) ? 2'h1 : 2'h2;
            end else begin
                ainc_ff <= 2'h0;
            end
        end
    end

    // Serial bookkeeping for the closing flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ff <= 16'h0000;
            ser_load_ff <= 1'b0;
            ser_byte_ff <= 1'b0;
        end else if (sif.go) begin
            src_ff <= source_operand;
            ser_load_ff <= sif.load;
            ser_byte_ff <= ser_n <= 5'(mmbx_pkg::BYTE_MAX);
        end
    end

    assign ser_val = ser_load_ff ? src_ff : sif.rdata;

    // Results, write strobes and status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_ff <= 16'h0000;
            lo_ff <= 16'h0000;
            whi_ff <= 1'b0;
            wlo_ff <= 1'b0;
            wsrc_ff <= 1'b0;
            done_ff <= 1'b0;
            st_ff <= mmbx_pkg::ST_RESET;
            touch_ff <= 6'h00;
        end else begin
            whi_ff <= 1'b0;
            wlo_ff <= 1'b0;
            wsrc_ff <= 1'b0;
            done_ff <= 1'b0;
            if (take && !ser_op) begin
                done_ff <= 1'b1;
                touch_ff <= 6'h00;
                if (is_shift) begin
                    hi_ff <= shr[15:0];
                    whi_ff <= 1'b1;
                    st_ff[2:0] <= cmp_zero(shr[15:0], 1'b0);
                    st_ff[mmbx_pkg::ST_CARRY] <= shr[16];
                    touch_ff <= 6'h0F;
                    if (shk == mmbx_pkg::SH_ARITH_LEFT) begin
                        st_ff[mmbx_pkg::ST_OVF] <= shr[17];
                        touch_ff <= 6'h1F;
                    end
                end else begin
                    unique case (opc)
                        mmbx_pkg::OP_ONES_MASK: begin
                            st_ff[mmbx_pkg::ST_EQ] <= (dest_reg & source_operand) == source_operand;
                            touch_ff <= 6'h04;
                        end
                        mmbx_pkg::OP_ZERO_MASK: begin
                            st_ff[mmbx_pkg::ST_EQ] <= (dest_reg & source_operand) == 16'h0000;
                            touch_ff <= 6'h04;
                        end
                        mmbx_pkg::OP_XOR: begin
                            hi_ff <= dest_reg ^ source_operand;
                            whi_ff <= 1'b1;
                            st_ff[2:0] <= cmp_zero(dest_reg ^ source_operand, 1'b0);
                            touch_ff <= 6'h07;
                        end
                        mmbx_pkg::OP_MUL: begin
                            hi_ff <= prod[31:16];
                            lo_ff <= prod[15:0];
                            whi_ff <= 1'b1;
                            wlo_ff <= 1'b1;
                        end
                        mmbx_pkg::OP_DIV: begin
                            touch_ff <= 6'h10;
                            if (source_operand <= dest_reg) begin
                                st_ff[mmbx_pkg::ST_OVF] <= 1'b1;
                            end else begin
                                st_ff[mmbx_pkg::ST_OVF] <= 1'b0;
                                hi_ff <= quo;
                                lo_ff <= rem;
                                whi_ff <= 1'b1;
                                wlo_ff <= 1'b1;
                            end
                        end
                        default: begin
                            // Not this group: finish with nothing touched
                        end
                    endcase
                end
            end else if (state_ff == EX_SERIAL && sif.done) begin
                done_ff <= 1'b1;
                st_ff[2:0] <= cmp_zero(ser_val, ser_byte_ff);
                touch_ff <= 6'h07;
                if (ser_byte_ff) begin
                    st_ff[mmbx_pkg::ST_PAR] <= ^ser_val[7:0];
                    touch_ff <= 6'h27;
                end
                if (!ser_load_ff) begin
                    hi_ff <= sif.rdata;
                    wsrc_ff <= 1'b1;
                end
            end
        end
    end

    assign exec_done = done_ff;
    assign result_hi = hi_ff;
    assign result_lo = lo_ff;
    assign write_hi = whi_ff;
    assign write_lo = wlo_ff;
    assign write_src = wsrc_ff;
    assign status_flags = st_ff;
    assign status_touched = touch_ff;
    assign pair_in_memory = pmem_ff;
    assign operand_is_byte = byte_ff;
    assign autoinc_step = ainc_ff;

    ones_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && !is_shift && opc == mmbx_pkg::OP_ONES_MASK |=> exec_done && !write_hi &&
        status_flags[mmbx_pkg::ST_EQ] == (($past(dest_reg) & $past(source_operand)) == $past(source_operand)))
        else $error("ones mask compare wrong");
    zero_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && !is_shift && opc == mmbx_pkg::OP_ZERO_MASK |=> !write_hi && !write_lo &&
        status_flags[mmbx_pkg::ST_EQ] == (($past(dest_reg) & $past(source_operand)) == 16'h0000))
        else $error("zeros mask compare wrong");
    xor_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && !is_shift && opc == mmbx_pkg::OP_XOR |=> write_hi &&
        result_hi == ($past(dest_reg) ^ $past(source_operand)) && status_touched == 6'h07)
        else $error("exclusive OR result wrong");
    mul_result_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && !is_shift && opc == mmbx_pkg::OP_MUL |=> write_hi && write_lo &&
        {result_hi, result_lo} == 32'($past(dest_reg)) * 32'($past(source_operand)) && status_touched == 6'h00)
        else $error("multiply product wrong");
    pair_memory_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && opc == mmbx_pkg::OP_DIV && dest_index == mmbx_pkg::LAST_WREG |=> pair_in_memory)
        else $error("register 15 pair not flagged");
    div_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && opc == mmbx_pkg::OP_DIV && source_operand <= dest_reg |=>
        status_flags[mmbx_pkg::ST_OVF] && !write_hi && !write_lo)
        else $error("divide overflow not handled");
    left_ovf_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && is_shift && shk == mmbx_pkg::SH_ARITH_LEFT && shcnt == 4'h1 && dest_reg[14] |=>
        status_flags[mmbx_pkg::ST_OVF] && status_touched == 6'h1F)
        else $error("left shift overflow missed");
    ser_parity_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_ff == EX_SERIAL && sif.done && !ser_byte_ff |=> exec_done && !status_touched[mmbx_pkg::ST_PAR])
        else $error("parity touched on word transfer");
endmodule
`default_nettype wire

// ==== src/mmbx_pkg.sv ====
package mmbx_pkg;
    // Opcodes in the six leading instruction bits
    localparam logic [5:0] OP_ONES_MASK = 6'h08;
    localparam logic [5:0] OP_ZERO_MASK = 6'h09;
    localparam logic [5:0] OP_XOR = 6'h0A;
    localparam logic [5:0] OP_SER_LOAD = 6'h0C;
    localparam logic [5:0] OP_SER_STORE = 6'h0D;
    localparam logic [5:0] OP_MUL = 6'h0E;
    localparam logic [5:0] OP_DIV = 6'h0F;
    // Shift group: eight leading bits, low two pick the kind
    localparam logic [5:0] OP_SHIFT_HI = 6'h02;
    localparam logic [1:0] SH_ARITH_RIGHT = 2'h0;
    localparam logic [1:0] SH_LOGIC_RIGHT = 2'h1;
    localparam logic [1:0] SH_ARITH_LEFT = 2'h2;
    localparam logic [1:0] SH_ROTATE_RIGHT = 2'h3;
    // Field positions (bit 0 is the least significant here)
    localparam int OPC_LSB = 10;
    localparam int SHK_LSB = 8;
    localparam int DST_LSB = 6;
    localparam int BCNT_LSB = 6;
    localparam int SHCNT_LSB = 4;
    localparam int MODE_LSB = 4;
    localparam int REG_LSB = 0;
    localparam int IOBASE_LSB = 1;
    localparam logic [3:0] LAST_WREG = 4'hF;
    localparam logic [1:0] MODE_AUTOINC = 2'h3;
    localparam int BYTE_MAX = 8;
    // Status bit positions
    localparam int ST_LGT = 0;
    localparam int ST_AGT = 1;
    localparam int ST_EQ = 2;
    localparam int ST_CARRY = 3;
    localparam int ST_OVF = 4;
    localparam int ST_PAR = 5;
    localparam logic [5:0] ST_RESET = 6'h00;
    // Serial bit slot timing
    localparam int CLK_NS = 50;
    localparam int BIT_SLOT_NS = 200;
    localparam int BIT_CYCLES = (BIT_SLOT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ==== src/mmbx_ser_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mmbx_ser_if;
    logic go; // One-cycle launch
    logic load; // 1 send bits out, 0 collect bits in
    logic [4:0] cnt; // Bits to move, 1 to 16
    logic [11:0] base; // Starting bit address
    logic [15:0] wdata; // Bits to send, LSB first
    logic done; // One-cycle end pulse
    logic [15:0] rdata; // Collected bits, zero filled
    modport ctl (output go, load, cnt, base, wdata, input done, rdata);
    modport eng (input go, load, cnt, base, wdata, output done, rdata);
endinterface
`default_nettype wire

// ==== src/mmbx_serial.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmbx_serial (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control from the datapath
    mmbx_ser_if.eng sif,
    // Bit-serial space
    output logic [11:0] io_bit_addr,
    output logic io_bit_out,
    output logic io_bit_strobe,
    input wire logic io_bit_in_sync
);
    typedef enum logic {SER_IDLE, SER_RUN} mmbx_ser_e;
    mmbx_ser_e state_ff; // Engine state
    logic [7:0] div_ff; // Cycle within a bit slot
    logic [4:0] idx_ff; // Bit being moved
    logic [4:0] cnt_ff; // Bits requested
    logic load_ff; // Direction
    logic [15:0] sh_ff; // Outgoing bits, shifted right
    logic [15:0] rd_ff; // Incoming bits
    logic [11:0] addr_ff; // Private bit address
    logic done_ff; // End pulse
    logic slot_end; // Last cycle of a bit slot

    assign slot_end = (div_ff == 8'(mmbx_pkg::BIT_CYCLES - 1));

    // Slot divider gives the bit rate as an enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 8'h00;
        end else if (sif.go || slot_end || state_ff == SER_IDLE) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Sequencing of bits and the end pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SER_IDLE;
            idx_ff <= 5'h00;
            cnt_ff <= 5'h00;
            load_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (state_ff)
                SER_IDLE: begin
                    if (sif.go) begin
                        state_ff <= SER_RUN;
                        idx_ff <= 5'h00;
                        cnt_ff <= sif.cnt;
                        load_ff <= sif.load;
                    end
                end
                SER_RUN: begin
                    if (slot_end) begin
                        idx_ff <= idx_ff + 5'h01;
                        // Stop after the requested count
                        if (idx_ff == cnt_ff - 5'h01) begin
                            state_ff <= SER_IDLE;
                            done_ff <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Address walks on, the base register itself is never written back
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= 12'h000;
        end else if (sif.go) begin
            addr_ff <= sif.base;
        end else if (state_ff == SER_RUN && slot_end) begin
            addr_ff <= addr_ff + 12'h001;
        end
    end

    // Data: least significant bit first both ways
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_ff <= 16'h0000;
            rd_ff <= 16'h0000;
        end else if (sif.go) begin
            sh_ff <= sif.wdata;
            rd_ff <= 16'h0000; // Unfilled positions stay zero
        end else if (state_ff == SER_RUN && slot_end) begin
            sh_ff <= {1'b0, sh_ff[15:1]};
            if (!load_ff) begin
                rd_ff[idx_ff[3:0]] <= io_bit_in_sync;
            end
        end
    end

    // Strobe at slot start so the far side sees a settled address
    assign io_bit_strobe = (state_ff == SER_RUN) && load_ff && (div_ff == 8'h00);
    assign io_bit_out = sh_ff[0];
    assign io_bit_addr = addr_ff;
    assign sif.done = done_ff;
    assign sif.rdata = rd_ff;

    addr_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        sif.go && state_ff == SER_IDLE |=> io_bit_addr == $past(sif.base))
        else $error("bit address not loaded from base");
endmodule
`default_nettype wire

// ==== tb/mmbx_io_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side bit space: fixed input levels, records what loads send
module mmbx_io_model #(
    parameter logic [15:0] PAT = 16'hB3A6
) (
    // Clock
    input wire logic clk,
    // Bit space, low four address bits pick the place
    input wire logic [11:0] io_bit_addr,
    input wire logic io_bit_out,
    input wire logic io_bit_strobe,
    output logic io_bit_in,
    // Captured load bits for the bench
    output logic [15:0] cap
);
    // Level of the addressed input place; it follows the address
    assign io_bit_in = PAT[io_bit_addr[3:0]];
    // Take each sent bit at its strobe
    always_ff @(posedge clk) begin
        if (io_bit_strobe) begin
            cap[io_bit_addr[3:0]] <= io_bit_out;
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_mask_muldiv_bitio_shift_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_mask_muldiv_bitio_shift_exec;
    localparam logic [15:0] P = 16'hB3A6; // Far side input levels
    logic clk = 1'b0, rst_n = 1'b0, go = 1'b0;
    logic [15:0] iw = 16'h0000, sa = 16'h0000, dr = 16'h0000, dn = 16'h0000, r0 = 16'h0000, r12 = 16'h0000;
    logic done, byt, wh, wl, wsr, bo, bs, bi, bsy, pmem, unk;
    logic [3:0] di, sr;
    logic [1:0] step, sm;
    logic [5:0] fl, tch;
    logic [15:0] rh, rl, cap;
    logic [11:0] ba;
    int mismatches = 0, num_checks = 0;
    always #25 clk = ~clk;
    mmbx_exec i_dut (.clk(clk), .rst_n(rst_n), .exec_start(go), .instr_word(iw), .source_operand(sa),
        .dest_reg(dr), .dest_next(dn), .count_reg_zero(r0), .io_base_reg(r12), .exec_busy(bsy),
        .dest_index(di), .src_mode(sm), .src_reg(sr), .pair_in_memory(pmem), .operand_is_byte(byt),
        .autoinc_step(step), .unknown_op(unk),
        .exec_done(done), .result_hi(rh), .result_lo(rl), .write_hi(wh), .write_lo(wl), .write_src(wsr),
        .status_flags(fl), .status_touched(tch), .io_bit_addr(ba), .io_bit_out(bo), .io_bit_strobe(bs),
        .io_bit_in(bi));
    mmbx_io_model #(.PAT(P)) i_io (.clk(clk), .io_bit_addr(ba), .io_bit_out(bo), .io_bit_strobe(bs),
        .io_bit_in(bi), .cap(cap));
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One request; a free cycle first so busy has dropped
    task automatic run(input logic [15:0] i);
        int n;
        @(negedge clk);
        chk("idle", 16'(bsy), 16'h0000);
        iw = i;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (n = 0; n < 99 && done !== 1'b1; n++) @(negedge clk);
        if (done !== 1'b1) begin
            mismatches++;
            finish_test();
        end
        chk("busy", 16'(bsy), 16'h0001);
    endtask
    // Compare-with-zero flags, sign at bit 7 for byte results
    function automatic logic [5:0] z(input logic [15:0] v, input logic b);
        z = {b & ^v[7:0], 2'b00, v == 0, !(b ? v[7] : v[15]) && v != 0, v != 0};
    endfunction
    initial begin
        logic [15:0] s, d, e, v;
        logic [31:0] p;
        logic [5:0] f, m;
        logic [3:0] c;
        logic [1:0] wr, kd;
        logic [9:0] fld;
        logic cy, o;
        int k, n, t, j;
        void'($urandom(32'h7941));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        for (t = 0; t < 54; t++) begin
            d = 16'($urandom) | (t % 9 == 7 ? 16'h4000 : 16'h0000);
            s = (t % 5 == 0) ? d : 16'($urandom);
            dn = $urandom;
            r0 = (t % 3 == 0) ? 16'h0000 : 16'($urandom);
            c = (t % 4 == 0) ? 4'h0 : (t % 4 == 3) ? 4'h1 : 4'($urandom);
            k = t % 9;
            kd = 2'(k - 5);
            fld = 10'($urandom) | (t % 2 == 1 ? 10'h3C0 : 10'h000);
            dr = d;
            sa = s;
            e = 16'h0000; v = 16'h0000; f = 6'h00; m = 6'h00; wr = 2'h0;
            case (k)
                0: begin f = {3'b000, (d & s) == s, 2'b00}; m = 6'h04; run({mmbx_pkg::OP_ONES_MASK, fld}); end
                1: begin f = {3'b000, (d & s) == 0, 2'b00}; m = 6'h04; run({mmbx_pkg::OP_ZERO_MASK, fld}); end
                2: begin e = d ^ s; f = z(e, 1'b0); m = 6'h07; wr = 2'h2; run({mmbx_pkg::OP_XOR, fld}); end
                3: begin p = d * s; {e, v} = p; wr = 2'h3; run({mmbx_pkg::OP_MUL, fld}); end
                4: begin
                    // Overflow bit is rewritten on every divide, cleared when none
                    p = {d, dn};
                    m = 6'h10;
                    if (s <= d) begin f = 6'h10; end
                    else begin e = 16'(p / s); v = 16'(p % s); wr = 2'h3; end
                    run({mmbx_pkg::OP_DIV, fld});
                end
                default: begin
                    n = c != 0 ? c : r0[3:0] != 0 ? r0[3:0] : 16;
                    v = d; cy = 1'b0; o = 1'b0;
                    for (j = 0; j < n; j++) begin
                        if (kd == 2'h2) begin cy = v[15]; v = {v[14:0], 1'b0}; o |= v[15]; end
                        else begin cy = v[0]; v = {kd == 2'h3 ? v[0] : kd == 2'h0 ? v[15] : 1'b0, v[15:1]}; end
                    end
                    e = v; v = 16'h0000; wr = 2'h2;
                    f = z(e, 1'b0) | {1'b0, o, cy, 3'b000};
                    m = kd == 2'h2 ? 6'h1F : 6'h0F;
                    run({mmbx_pkg::OP_SHIFT_HI, kd, c, 4'($urandom)});
                end
            endcase
            chk("flags", 16'(fl & m), 16'(f));
            chk("touched", 16'(tch), 16'(m));
            chk("writes", 16'({wh, wl}), 16'(wr));
            if (wr[1]) chk("hi", rh, e);
            if (wr[0]) chk("lo", rl, v);
            // Register 15 pairing only for multiply and divide
            j = (k == 3 || k == 4) && iw[9:6] == 4'hF;
            chk("side", 16'({pmem, unk, step, byt}), 16'(j * 16));
            chk("decode", 16'({di, sm, sr}), 16'(iw[9:0]));
        end
        for (t = 0; t < 8; t++) begin
            c = t[2:1] == 0 ? 4'h1 : t[2:1] == 1 ? 4'h8 : t[2:1] == 2 ? 4'h9 : 4'h0;
            n = c == 0 ? 16 : c;
            r12 = $urandom;
            sa = $urandom;
            e = 16'h0000;
            for (j = 0; j < n; j++) e[j] = t[0] ? P[4'(r12[4:1] + j)] : sa[j];
            run({t[0] ? mmbx_pkg::OP_SER_STORE : mmbx_pkg::OP_SER_LOAD, c, 2'h3, 4'h1});
            for (j = 0; j < n && !t[0]; j++) chk("sent", 16'(cap[4'(r12[4:1] + j)]), 16'(e[j]));
            if (t[0]) chk("stored", rh, e);
            // Loads compare the whole operand for words, only its low eight bits for bytes, sign at bit 7
            v = t[0] ? e : n <= 8 ? 16'(sa[7:0]) : sa;
            chk("flags", 16'(fl & (n <= 8 ? 6'h27 : 6'h07)), 16'(z(v, n <= 8)));
            chk("writes", 16'({wh, wl, wsr}), 16'(t[0]));
            chk("touched", 16'(tch), n <= 8 ? 16'h0027 : 16'h0007);
            chk("sizing", 16'({byt, step}), n <= 8 ? 16'h0005 : 16'h0002);
        end
        // Opcode outside the group: done with nothing touched or written
        run({6'h0B, 10'($urandom)});
        chk("unknown", 16'({unk, tch, wh, wl, wsr}), 16'h0200);
        finish_test();
    end
endmodule
`default_nettype wire
